// >>> rtl/srb_ctrl.sv
// Reset sequencing, strap decode and port reset outputs of the switch.
// Straps and the fundamental reset pin are asynchronous and synchronised
// here; software controls arrive as same-clock pulses.
`timescale 1ns/1ps
// Notes on behaviour
// - Fundamental reset clears logic, resets links.
// - Hold input keeps device halted, SMBus alive.
// - Clearing halt bit starts normal operation.
// - Mode strap 0 normal, 1 EEPROM, rest reserved.
// - Slow strap gives 100 KHz, else 400 KHz.
// - No software override of SMBus speed.
// - Downstream strap seeds downstream clock bits.
// - Each downstream clock bit written independently.
// - Upstream strap seeds upstream clock bit.
// - Software write overrides upstream clock bit.
// - Pin 11 is GPIO or port 6 reset.
// - Pins 0, 1 give ports 2, 4 resets.
module srb_ctrl
  import srb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic fundamental_reset_n,
  input wire srb_straps_s straps,
  input wire logic halt_clear,
  input wire logic [NUM_DS-1:0] ds_sclk_we,
  input wire logic [NUM_DS-1:0] ds_sclk_wdata,
  input wire logic us_sclk_we,
  input wire logic us_sclk_wdata,
  input wire logic [NUM_DS-1:0] ds_link_reset,
  input wire logic [GPIO_W-1:0] gpio_alt_en,
  input wire logic [GPIO_W-1:0] gpio_out,
  input wire logic [GPIO_W-1:0] gpio_oe,
  input wire logic [GPIO_W-1:0] gpio_pin_in,
  output logic [GPIO_W-1:0] gpio_pin_out,
  output logic [GPIO_W-1:0] gpio_pin_oe,
  output logic [GPIO_W-1:0] gpio_in,
  output logic logic_reset,
  output logic link_reset,
  output logic smbus_enable,
  output logic switch_run,
  output logic reset_hold_request,
  output srb_mode_s mode,
  output logic smbus_slow,
  output logic smbus_tick,
  output logic [NUM_DS-1:0] ds_sclk,
  output logic us_sclk
);
  // Synchronisers: first stage feeds only the second stage
  logic perst_s1_r, perst_s2_r;
  srb_straps_s strap_s1_r, strap_s2_r;
  logic [GPIO_W-1:0] gin_s1_r, gin_s2_r;

  // Pin reset is asynchronous to sys_clk
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      perst_s1_r <= 1'b0;
      perst_s2_r <= 1'b0;
    end else begin
      perst_s1_r <= fundamental_reset_n;
      perst_s2_r <= perst_s1_r;
    end
  end

  // Straps sampled every cycle; the sequencer decides when to keep them
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      strap_s1_r <= '0;
      strap_s2_r <= '0;
    end else begin
      strap_s1_r <= straps;
      strap_s2_r <= strap_s1_r;
    end
  end

  // General purpose pin inputs
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      gin_s1_r <= '0;
      gin_s2_r <= '0;
    end else begin
      gin_s1_r <= gpio_pin_in;
      gin_s2_r <= gin_s1_r;
    end
  end

  // Sequencer state
  srb_state_e state_r, state_nxt;
  logic [7:0] proc_cnt_r, proc_cnt_nxt;
  logic halt_bit_r, halt_bit_nxt;
  srb_straps_s latched_r, latched_nxt;

  always_comb begin
    state_nxt = state_r;
    proc_cnt_nxt = proc_cnt_r;
    halt_bit_nxt = halt_bit_r;
    latched_nxt = latched_r;
    unique case (state_r)
      SRB_RESET: begin
        proc_cnt_nxt = '0;
        halt_bit_nxt = 1'b0;
        latched_nxt = strap_s2_r;
        if (perst_s2_r) begin
          state_nxt = SRB_PROC;
        end
      end
      SRB_PROC: begin
        proc_cnt_nxt = proc_cnt_r + 8'h01;
        if (proc_cnt_r == RESET_PROC_CYCLES - 8'h01) begin
          if (latched_r.hold_req) begin
            halt_bit_nxt = 1'b1;
            state_nxt = SRB_HALT;
          end else begin
            state_nxt = SRB_RUN;
          end
        end
      end
      SRB_HALT: begin
        if (halt_clear) begin
          halt_bit_nxt = 1'b0;
          state_nxt = SRB_RUN;
        end
      end
      SRB_RUN: begin
        state_nxt = SRB_RUN;
      end
    endcase
    if (!perst_s2_r) begin
      state_nxt = SRB_RESET;
      halt_bit_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= SRB_RESET;
      proc_cnt_r <= '0;
      halt_bit_r <= 1'b0;
      latched_r <= '0;
    end else begin
      state_r <= state_nxt;
      proc_cnt_r <= proc_cnt_nxt;
      halt_bit_r <= halt_bit_nxt;
      latched_r <= latched_nxt;
    end
  end

  // Status and control outputs
  logic logic_reset_nxt, link_reset_nxt, smb_en_nxt, run_nxt;
  srb_mode_s mode_nxt;
  always_comb begin
    logic_reset_nxt = (state_nxt == SRB_RESET);
    link_reset_nxt = (state_nxt != SRB_RUN);
    smb_en_nxt = (state_nxt == SRB_HALT) || (state_nxt == SRB_RUN);
    run_nxt = (state_nxt == SRB_RUN);
    mode_nxt = '0;
    // mode strap decode
    // Reserved codes still run; software sees the flag
    case (latched_nxt.switch_mode)
      MODE_NORMAL: begin
        mode_nxt.normal = 1'b1;
      end
      MODE_EEPROM: begin
        mode_nxt.normal = 1'b1;
        mode_nxt.eeprom_init = 1'b1;
      end
      default: begin
        mode_nxt.reserved = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      logic_reset <= 1'b1;
      link_reset <= 1'b1;
      smbus_enable <= 1'b0;
      switch_run <= 1'b0;
      reset_hold_request <= 1'b0;
      mode <= '0;
    end else begin
      logic_reset <= logic_reset_nxt;
      link_reset <= link_reset_nxt;
      smbus_enable <= smb_en_nxt;
      switch_run <= run_nxt;
      reset_hold_request <= halt_bit_nxt;
      mode <= mode_nxt;
    end
  end

  // Slot clock bits: straps reload while in reset, writes win after
  logic [NUM_DS-1:0] ds_sclk_nxt;
  logic us_sclk_nxt;
  always_comb begin
    for (int i = 0; i < NUM_DS; i++) begin
      if (state_nxt == SRB_RESET) begin
        ds_sclk_nxt[i] = latched_nxt.cclk_ds;
      end else if (ds_sclk_we[i]) begin
        ds_sclk_nxt[i] = ds_sclk_wdata[i];
      end else begin
        ds_sclk_nxt[i] = ds_sclk[i];
      end
    end
    if (state_nxt == SRB_RESET) begin
      us_sclk_nxt = latched_nxt.cclk_us;
    end else if (us_sclk_we) begin
      us_sclk_nxt = us_sclk_wdata;
    end else begin
      us_sclk_nxt = us_sclk;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ds_sclk <= '0;
      us_sclk <= 1'b0;
    end else begin
      ds_sclk <= ds_sclk_nxt;
      us_sclk <= us_sclk_nxt;
    end
  end

  // Master SMBus clock tick; speed comes from the strap only
  logic [SMB_CNT_W-1:0] smb_cnt_r, smb_cnt_nxt;
  logic smb_tick_nxt, smb_slow_nxt;
  always_comb begin
    smb_slow_nxt = latched_nxt.smbus_slow;
    smb_tick_nxt = 1'b0;
    smb_cnt_nxt = smb_cnt_r + 1'b1;
    if (!smb_en_nxt) begin
      smb_cnt_nxt = '0;
    end else if (smb_cnt_r == SMB_CNT_W'(smb_slow_nxt ?
        SMB_SLOW_HALF - 1 : SMB_FAST_HALF - 1)) begin
      smb_cnt_nxt = '0;
      smb_tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      smbus_slow <= 1'b0;
      smbus_tick <= 1'b0;
      smb_cnt_r <= '0;
    end else begin
      smbus_slow <= smb_slow_nxt;
      smbus_tick <= smb_tick_nxt;
      smb_cnt_r <= smb_cnt_nxt;
    end
  end

  // GPIO with alternate port reset functions
  logic [GPIO_W-1:0] gpo_nxt, goe_nxt;
  always_comb begin
    gpo_nxt = gpio_out;
    goe_nxt = gpio_oe;
    if (gpio_alt_en[GPIO_P2]) begin
      gpo_nxt[GPIO_P2] = !(link_reset_nxt || ds_link_reset[0]);
      goe_nxt[GPIO_P2] = 1'b1;
    end
    if (gpio_alt_en[GPIO_P4]) begin
      gpo_nxt[GPIO_P4] = !(link_reset_nxt || ds_link_reset[1]);
      goe_nxt[GPIO_P4] = 1'b1;
    end
    if (gpio_alt_en[GPIO_P6]) begin
      gpo_nxt[GPIO_P6] = !(link_reset_nxt || ds_link_reset[2]);
      goe_nxt[GPIO_P6] = 1'b1;
    end
    // Drive only the enabled port reset pins before the reset sequence decides pin roles
    if (logic_reset_nxt) begin
      goe_nxt = '0;
      goe_nxt[GPIO_P2] = gpio_alt_en[GPIO_P2];
      goe_nxt[GPIO_P4] = gpio_alt_en[GPIO_P4];
      goe_nxt[GPIO_P6] = gpio_alt_en[GPIO_P6];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      gpio_pin_out <= '0;
      gpio_pin_oe <= '0;
      gpio_in <= '0;
    end else begin
      gpio_pin_out <= gpo_nxt;
      gpio_pin_oe <= goe_nxt;
      gpio_in <= gin_s2_r;
    end
  end
endmodule

// >>> rtl/srb_pkg.sv
// Package for the switch reset and boot strap control block.
// Assumes a single 20 MHz system clock domain.
package srb_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned SMB_FAST_HZ = 400000;
  localparam int unsigned SMB_SLOW_HZ = 100000;
  // Half periods of the master SMBus clock, rounded down
  localparam int unsigned SMB_FAST_HALF = CLK_HZ / (2 * SMB_FAST_HZ);
  localparam int unsigned SMB_SLOW_HALF = CLK_HZ / (2 * SMB_SLOW_HZ);
  localparam int unsigned SMB_CNT_W = 8;
  // Length of the internal reset procedure in cycles
  localparam logic [7:0] RESET_PROC_CYCLES = 8'h10;
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_EEPROM = 3'h1;
  localparam int unsigned NUM_DS = 3;
  localparam int unsigned GPIO_W = 16;
  localparam int unsigned GPIO_P2 = 0;
  localparam int unsigned GPIO_P4 = 1;
  localparam int unsigned GPIO_P6 = 11;

  typedef enum logic [1:0] {
    SRB_RESET = 2'b00,
    SRB_PROC = 2'b01,
    SRB_HALT = 2'b10,
    SRB_RUN = 2'b11
  } srb_state_e;

  typedef struct packed {
    logic [2:0] switch_mode;
    logic smbus_slow;
    logic cclk_ds;
    logic cclk_us;
    logic hold_req;
  } srb_straps_s;

  typedef struct packed {
    logic eeprom_init;
    logic normal;
    logic reserved;
  } srb_mode_s;
endpackage

// >>> sim/srb_ctrl_chk.sv
// Port checker for srb_ctrl, bound to every instance.
// Assumes the board holds the straps after reset release.
`timescale 1ns/1ps
module srb_ctrl_chk
  import srb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic fundamental_reset_n,
  input wire srb_straps_s straps,
  input wire logic halt_clear,
  input wire logic [NUM_DS-1:0] ds_sclk_we,
  input wire logic [NUM_DS-1:0] ds_sclk_wdata,
  input wire logic us_sclk_we,
  input wire logic us_sclk_wdata,
  input wire logic logic_reset,
  input wire logic link_reset,
  input wire logic smbus_enable,
  input wire logic switch_run,
  input wire logic reset_hold_request,
  input wire srb_mode_s mode,
  input wire logic smbus_slow,
  input wire logic smbus_tick,
  input wire logic [NUM_DS-1:0] ds_sclk,
  input wire logic us_sclk
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  chk_pin_resets: assert property (
    !fundamental_reset_n [*5] |-> logic_reset && link_reset && !switch_run)
    else $error("pin reset not taken");
  chk_halt_holds: assert property (
    reset_hold_request |-> smbus_enable && link_reset && !switch_run)
    else $error("halt not held");
  chk_clear_runs: assert property (
    reset_hold_request && halt_clear |=> switch_run && !reset_hold_request)
    else $error("halt clear ignored");
  chk_mode_decode: assert property (
    smbus_enable && fundamental_reset_n |->
      smbus_slow == straps.smbus_slow &&
      mode == {straps.switch_mode == MODE_EEPROM,
      straps.switch_mode <= MODE_EEPROM, straps.switch_mode > MODE_EEPROM})
    else $error("strap decode wrong");
  chk_fast_tick: assert property (
    $rose(smbus_enable) && !smbus_slow ##24 smbus_enable |->
      smbus_tick ##1 !smbus_tick [*8])
    else $error("fast tick wrong");
  chk_ds_write: assert property (
    !logic_reset && $past(fundamental_reset_n, 2) && ds_sclk_we == 3'h2 |=>
      ds_sclk ==
      {$past(ds_sclk[2]), $past(ds_sclk_wdata[1]), $past(ds_sclk[0])})
    else $error("port write wrong");
  chk_us_write: assert property (
    !logic_reset && $past(fundamental_reset_n, 2) && us_sclk_we |=>
      us_sclk == $past(us_sclk_wdata))
    else $error("upstream write wrong");
  chk_strap_seed: assert property (
    $rose(smbus_enable) |-> {ds_sclk, us_sclk, reset_hold_request} ==
      {{NUM_DS{straps.cclk_ds}}, straps.cclk_us, straps.hold_req})
    else $error("strap seed wrong");
  cover property (reset_hold_request && halt_clear);
  cover property (smbus_tick && smbus_slow);
  cover property ($rose(switch_run));
endmodule

bind srb_ctrl srb_ctrl_chk chk_i (.*);

// >>> sim/srb_board.sv
// Board model: fundamental reset pin and strap resistors.
// Assumes the bench requests reset through rst_req.
`timescale 1ns/1ps
module srb_board
  import srb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_req,
  input wire srb_straps_s cfg,
  output logic fundamental_reset_n,
  output srb_straps_s straps
);
  always_ff @(posedge sys_clk) begin
    fundamental_reset_n <= !rst_req;
    if (rst_req) begin
      straps <= cfg;
    end
  end
endmodule

// >>> sim/switch_reset_boot_strap_control_tb_top.sv
// Bench for srb_ctrl: boots under each strap set and checks the ports.
// Assumes the board model drives the reset pin and the straps.
`timescale 1ns/1ps
module switch_reset_boot_strap_control_tb_top
  import srb_pkg::*;
;
  logic sys_clk = 0, resetn = 0, rst_req = 1, halt_clear = 0;
  logic us_sclk_we = 0, us_sclk_wdata = 0;
  logic [2:0] ds_sclk_we = 0, ds_sclk_wdata = 0, ds_link_reset = 0;
  logic [15:0] gpio_alt_en = 16'h0803, gpio_out = 0, gpio_oe = 0;
  logic [15:0] gpio_pin_in = 0, gpio_pin_out, gpio_pin_oe, gpio_in;
  logic fundamental_reset_n, logic_reset, link_reset, smbus_enable;
  logic switch_run, reset_hold_request, smbus_slow, smbus_tick, us_sclk;
  logic [2:0] ds_sclk;
  srb_straps_s cfg = '0, straps;
  srb_mode_s mode;
  int n_mismatch = 0, tests_run = 0;
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  srb_board board (.*);
  srb_ctrl DUT (.*);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic tick_n(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Waits are bounded so a stuck sequencer ends the run
  task automatic boot(input srb_straps_s s);
    int i;
    rst_req = 1;
    cfg = s;
    tick_n(4);
    rst_req = 0;
    for (i = 0; i < 60 && smbus_enable !== 1'b1; i++) tick_n(1);
    if (smbus_enable !== 1'b1) begin
      n_mismatch++;
      give_verdict();
    end
  endtask
  task automatic t_modes();
    int m;
    logic [15:0] n;
    for (m = 0; m < 8; m++) begin
      boot({m[2:0], m[1], m[0], !m[0], 1'b0});
      chk(mode, {m == 1, m <= 1, m > 1});
      chk({smbus_slow, ds_sclk, us_sclk, reset_hold_request, switch_run},
        {m[1], {3{m[0]}}, !m[0], 2'b01});
      n = 0;
      repeat (200) begin
        n += smbus_tick;
        tick_n(1);
      end
      chk(n, m[1] ? 2 : 8);
    end
  endtask
  task automatic t_hold();
    boot({3'h0, 1'b0, 1'b1, 1'b0, 1'b1});
    tick_n(40);
    rst_req = 1;
    tick_n(6);
    chk({reset_hold_request, smbus_enable, logic_reset}, 3'h1);
    boot({3'h0, 1'b0, 1'b1, 1'b0, 1'b1});
    tick_n(5);
    chk({reset_hold_request, switch_run, link_reset, gpio_pin_out[11],
      gpio_pin_out[1:0], smbus_enable}, 7'h51);
    halt_clear = 1;
    tick_n(1);
    halt_clear = 0;
    chk({reset_hold_request, switch_run, link_reset, gpio_pin_out[11],
      gpio_pin_out[1:0], gpio_pin_oe[11]}, 7'h2f);
    ds_link_reset = 3'h1;
    tick_n(1);
    chk(gpio_pin_out[1:0], 2'h2);
    ds_link_reset = 3'h4;
    tick_n(1);
    chk({gpio_pin_out[11], gpio_pin_out[1:0]}, 3'h3);
    ds_link_reset = 0;
  endtask
  task automatic t_writes();
    boot({3'h0, 1'b0, 1'b1, 1'b0, 1'b0});
    ds_sclk_we = 3'h2;
    tick_n(1);
    ds_sclk_we = 0;
    us_sclk_we = 1;
    us_sclk_wdata = 1;
    chk(ds_sclk, 3'h5);
    tick_n(1);
    us_sclk_we = 0;
    chk(us_sclk, 1'b1);
    rst_req = 1;
    tick_n(6);
    chk({logic_reset, link_reset, switch_run, smbus_enable}, 4'hc);
    boot({3'h0, 1'b0, 1'b1, 1'b0, 1'b0});
    chk({ds_sclk, us_sclk}, 4'he);
  endtask
  task automatic t_gpio();
    gpio_alt_en = 16'h0003;
    gpio_out = 16'h0a00;
    gpio_oe = 16'h0c00;
    gpio_pin_in = 16'h8421;
    tick_n(3);
    chk(gpio_pin_out, 16'h0a03);
    chk(gpio_pin_oe, 16'h0c03);
    chk(gpio_in, 16'h8421);
    gpio_alt_en = 16'h0803;
  endtask
  initial begin
    tick_n(8);
    resetn = 1;
    t_modes();
    t_hold();
    t_writes();
    t_gpio();
    give_verdict();
  end
endmodule
